/* psc_pkg.sv */
package psc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TEST = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0C;

    // control register fields
    localparam int CTRL_DRV_ON = 0;
    localparam int CTRL_CH_SEL = 1;
    localparam int CTRL_TAG_ON = 2;
    localparam int CTRL_PD_ON = 3;
    localparam int CTRL_CLAMP_ON = 4;
    localparam int CTRL_CLAMP_SYM = 5;
    localparam int CTRL_COMP_SEL = 6;
    localparam int CTRL_GAIN_LSB = 8;
    localparam int GAIN_W = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0008;

    // test register fields
    localparam int TEST_START = 0;

    // status register fields
    localparam int STAT_DRV_ACTIVE = 0;
    localparam int STAT_PARKED = 1;
    localparam int STAT_PULLDOWN = 2;
    localparam int STAT_STB_FAULT = 3;
    localparam int STAT_TEST_BUSY = 4;
    localparam int STAT_RESULT_VALID = 5;

    // result register fields
    localparam int ADC_W = 10;
    localparam int RES_OPEN_LSB = 0;
    localparam int RES_CLOSED_LSB = 16;

    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETTLE_NS = 2000;
    localparam int BALANCE_NS = 10000;
    localparam int CNT_W = 12;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BALANCE_CYC = (BALANCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // impedance test sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_SETTLE_OPEN = 3'b001,
        SEQ_WAIT_OPEN = 3'b010,
        SEQ_SETTLE_CLOSED = 3'b011,
        SEQ_WAIT_CLOSED = 3'b100,
        SEQ_BALANCE = 3'b101
    } psc_seq_e;

    // word-aligned register hit
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
        reg_hit = (addr[7:2] == off[7:2]);
    endfunction : reg_hit

endpackage : psc_pkg

/* psc_ahb_slave.sv */
module psc_ahb_slave (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // register file side
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data
);

    logic addr_phase;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;

    // zero wait state, always okay
    always_comb begin
        addr_phase = hsel & htrans[1] & hready;
        wr_pend_d = addr_phase & hwrite;
        wr_addr_d = addr_phase ? haddr[7:0] : wr_addr_q;
        hrdata_d = (addr_phase & ~hwrite) ? rd_data : 32'h0000_0000;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_q;
    assign wr_en = wr_pend_q;
    assign wr_addr = wr_addr_q;
    assign wr_data = hwdata;
    assign rd_addr = haddr[7:0];

endmodule : psc_ahb_slave

/* psc_imp_seq.sv */
module psc_imp_seq (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic start,
    output logic busy,
    output logic result_valid,
    output logic [psc_pkg::ADC_W-1:0] result_open,
    output logic [psc_pkg::ADC_W-1:0] result_closed,
    // converter
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [psc_pkg::ADC_W-1:0] adc_data,
    // switches
    output logic gnd_sw_on,
    output logic bg_sw_on,
    output logic ref_sw_open
);

    localparam logic [psc_pkg::CNT_W-1:0] SETTLE_LOAD = psc_pkg::CNT_W'(psc_pkg::SETTLE_CYC - 1);
    localparam logic [psc_pkg::CNT_W-1:0] BALANCE_LOAD = psc_pkg::CNT_W'(psc_pkg::BALANCE_CYC - 1);

    psc_pkg::psc_seq_e state_q, state_d;
    logic [psc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic valid_q, valid_d;
    logic [psc_pkg::ADC_W-1:0] res_open_q, res_open_d;
    logic [psc_pkg::ADC_W-1:0] res_closed_q, res_closed_d;
    logic adc_start_q, adc_start_d;
    logic gnd_q, gnd_d;
    logic bg_q, bg_d;
    logic ref_open_q, ref_open_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        valid_d = valid_q;
        res_open_d = res_open_q;
        res_closed_d = res_closed_q;
        adc_start_d = 1'b0;
        gnd_d = gnd_q;
        bg_d = bg_q;
        ref_open_d = ref_open_q;
        case (state_q)
            psc_pkg::SEQ_IDLE: begin
                if (start) begin
                    state_d = psc_pkg::SEQ_SETTLE_OPEN;
                    cnt_d = SETTLE_LOAD;
                    valid_d = 1'b0;
                    gnd_d = 1'b0;
                    ref_open_d = 1'b1; // [R12]
                end
            end
            psc_pkg::SEQ_SETTLE_OPEN: begin
                if (cnt_q == '0) begin
                    state_d = psc_pkg::SEQ_WAIT_OPEN;
                    adc_start_d = 1'b1; // [R14]
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            psc_pkg::SEQ_WAIT_OPEN: begin
                if (adc_done) begin
                    res_open_d = adc_data; // [R14]
                    state_d = psc_pkg::SEQ_SETTLE_CLOSED;
                    cnt_d = SETTLE_LOAD;
                    gnd_d = 1'b1; // [R14]
                end
            end
            psc_pkg::SEQ_SETTLE_CLOSED: begin
                if (cnt_q == '0) begin
                    state_d = psc_pkg::SEQ_WAIT_CLOSED;
                    adc_start_d = 1'b1; // [R14]
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            psc_pkg::SEQ_WAIT_CLOSED: begin
                if (adc_done) begin
                    res_closed_d = adc_data; // [R14]
                    state_d = psc_pkg::SEQ_BALANCE;
                    cnt_d = BALANCE_LOAD;
                    gnd_d = 1'b0;
                    bg_d = 1'b1; // [R15]
                end
            end
            psc_pkg::SEQ_BALANCE: begin
                if (cnt_q == '0) begin
                    state_d = psc_pkg::SEQ_IDLE;
                    bg_d = 1'b0; // [R15]
                    ref_open_d = 1'b0; // [R12]
                    valid_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                state_d = psc_pkg::SEQ_IDLE;
                gnd_d = 1'b0;
                bg_d = 1'b0;
                ref_open_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= psc_pkg::SEQ_IDLE;
            cnt_q <= '0;
            valid_q <= 1'b0;
            res_open_q <= '0;
            res_closed_q <= '0;
            adc_start_q <= 1'b0;
            gnd_q <= 1'b0;
            bg_q <= 1'b0;
            ref_open_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            valid_q <= valid_d;
            res_open_q <= res_open_d;
            res_closed_q <= res_closed_d;
            adc_start_q <= adc_start_d;
            gnd_q <= gnd_d;
            bg_q <= bg_d;
            ref_open_q <= ref_open_d;
        end
    end

    assign busy = (state_q != psc_pkg::SEQ_IDLE);
    assign result_valid = valid_q;
    assign result_open = res_open_q;
    assign result_closed = res_closed_q;
    assign adc_start = adc_start_q;
    assign gnd_sw_on = gnd_q;
    assign bg_sw_on = bg_q;
    assign ref_sw_open = ref_open_q;

endmodule : psc_imp_seq

/* psc_pump_switch_ctrl.sv */
// Behaviour
// R01: after reset the pump driver is off, all its pins are high impedance and parking is active.
// R02: while parked the parking amplifier is on, holding the control node near mid supply.
// R03: the first drive pin pull-down to analog ground is connected by default.
// R04: the pull-down drops by itself when the driver becomes active or a short to battery shows.
// R05: software may reconnect the pull-down, honoured only while the driver is off and no fault.
// R06: the driver is enabled by its bit only without a short to battery; enabling ends parking.
// R07: one of two output channels is driven by a select bit; the other stays high impedance.
// R08: a bit closes the selected channel's tag switch; when open its tag pin is high impedance.
// R09: while the driver is active software turns the sense-pin clamp on or off.
// R10: a bit picks a symmetric or asymmetric clamp range.
// R11: a bit connects compensation channel A or B; the other channel is high impedance.
// R12: the test sequencer opens the reference amplifier to compensation switch during the test.
// R13: a three-bit field selects one of eight filtered-output gains from 1 to 12.
// R14: the test converts the sense amplifier twice, ground switch open then closed, reports both.
// R15: after the test the band-gap switch on the test pin closes to restore charge balance.
// R16: every select and enable bit is active high and zero picks the default channel.
module psc_pump_switch_ctrl (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // fault and converter
    input wire logic sensor_stb_fault,
    input wire logic adc_done,
    input wire logic [psc_pkg::ADC_W-1:0] adc_data,
    output logic adc_start,
    // pump driver
    output logic pump_drv_en,
    output logic park_amp_on,
    output logic ch1_drive_en,
    output logic ch2_drive_en,
    output logic tag1_sw_on,
    output logic tag2_sw_on,
    output logic pulldown_sw_on,
    output logic clamp_en,
    output logic clamp_symmetric,
    // compensation network
    output logic comp_a_en,
    output logic comp_b_en,
    output logic ref_sw_a_on,
    output logic ref_sw_b_on,
    // filtered output amplifier
    output logic [psc_pkg::GAIN_W-1:0] gain_code,
    output logic [7:0] gain_onehot,
    // impedance test switches
    output logic test_gnd_sw_on,
    output logic test_bg_sw_on
);

    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    logic seq_start;
    logic seq_busy;
    logic seq_valid;
    logic [psc_pkg::ADC_W-1:0] res_open;
    logic [psc_pkg::ADC_W-1:0] res_closed;
    logic seq_ref_open;

    // software control bits and registered fault flag
    logic drv_bit_q, drv_bit_d;
    logic ch_sel_q, ch_sel_d;
    logic tag_q, tag_d;
    logic pd_q, pd_d;
    logic clamp_q, clamp_d;
    logic sym_q, sym_d;
    logic comp_q, comp_d;
    logic [psc_pkg::GAIN_W-1:0] gain_q, gain_d;
    logic stb_q;

    // registered switch outputs
    logic drv_act_q, drv_act_d;
    logic park_q, park_d;
    logic ch1_q, ch1_d;
    logic ch2_q, ch2_d;
    logic tag1_q, tag1_d;
    logic tag2_q, tag2_d;
    logic clamp_en_q, clamp_en_d;
    logic comp_a_q, comp_a_d;
    logic comp_b_q, comp_b_d;
    logic [7:0] onehot_q, onehot_d;

    psc_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .hwdata(hwdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    psc_imp_seq u_seq (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(seq_start),
        .busy(seq_busy),
        .result_valid(seq_valid),
        .result_open(res_open),
        .result_closed(res_closed),
        .adc_start(adc_start),
        .adc_done(adc_done),
        .adc_data(adc_data),
        .gnd_sw_on(test_gnd_sw_on),
        .bg_sw_on(test_bg_sw_on),
        .ref_sw_open(seq_ref_open)
    );

    // start pulse from a test register write
    assign seq_start = wr_en & psc_pkg::reg_hit(wr_addr, psc_pkg::OFF_TEST)
        & wr_data[psc_pkg::TEST_START]; // [R14]

    // control register write and hardware overrides
    always_comb begin
        logic ctrl_wr;
        ctrl_wr = wr_en & psc_pkg::reg_hit(wr_addr, psc_pkg::OFF_CTRL);
        drv_bit_d = drv_bit_q;
        ch_sel_d = ch_sel_q;
        tag_d = tag_q;
        clamp_d = clamp_q;
        sym_d = sym_q;
        comp_d = comp_q;
        gain_d = gain_q;
        pd_d = pd_q;
        if (ctrl_wr) begin
            drv_bit_d = wr_data[psc_pkg::CTRL_DRV_ON];
            ch_sel_d = wr_data[psc_pkg::CTRL_CH_SEL]; // [R16]
            tag_d = wr_data[psc_pkg::CTRL_TAG_ON];
            clamp_d = wr_data[psc_pkg::CTRL_CLAMP_ON];
            sym_d = wr_data[psc_pkg::CTRL_CLAMP_SYM];
            comp_d = wr_data[psc_pkg::CTRL_COMP_SEL];
            gain_d = wr_data[psc_pkg::CTRL_GAIN_LSB +: psc_pkg::GAIN_W]; // [R13]
            pd_d = wr_data[psc_pkg::CTRL_PD_ON]; // [R05]
        end
        // driver only runs with no short to battery
        drv_act_d = drv_bit_d & ~sensor_stb_fault; // [R06]
        // automatic pull-down release overrides any request
        if (drv_act_d | sensor_stb_fault) begin
            pd_d = 1'b0; // [R04] [R05]
        end
    end

    // switch decoding
    always_comb begin
        park_d = ~drv_act_d; // [R01] [R02] [R06]
        ch1_d = drv_act_d & ~ch_sel_d; // [R07]
        ch2_d = drv_act_d & ch_sel_d; // [R07]
        tag1_d = drv_act_d & ~ch_sel_d & tag_d; // [R08]
        tag2_d = drv_act_d & ch_sel_d & tag_d; // [R08]
        clamp_en_d = drv_act_d & clamp_d; // [R09]
        comp_a_d = ~comp_d; // [R11]
        comp_b_d = comp_d; // [R11]
        onehot_d = 8'h01 << gain_d; // [R13]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drv_bit_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_DRV_ON];
            ch_sel_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_CH_SEL];
            tag_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_TAG_ON];
            pd_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_PD_ON]; // [R03]
            clamp_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_CLAMP_ON];
            sym_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_CLAMP_SYM];
            comp_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_COMP_SEL];
            gain_q <= psc_pkg::CTRL_RESET[psc_pkg::CTRL_GAIN_LSB +: psc_pkg::GAIN_W];
            stb_q <= 1'b0;
            drv_act_q <= 1'b0; // [R01]
            park_q <= 1'b1; // [R01] [R02]
            ch1_q <= 1'b0;
            ch2_q <= 1'b0;
            tag1_q <= 1'b0;
            tag2_q <= 1'b0;
            clamp_en_q <= 1'b0;
            comp_a_q <= 1'b1;
            comp_b_q <= 1'b0;
            onehot_q <= 8'h01;
        end else begin
            drv_bit_q <= drv_bit_d;
            ch_sel_q <= ch_sel_d;
            tag_q <= tag_d;
            pd_q <= pd_d;
            clamp_q <= clamp_d;
            sym_q <= sym_d;
            comp_q <= comp_d;
            gain_q <= gain_d;
            stb_q <= sensor_stb_fault;
            drv_act_q <= drv_act_d;
            park_q <= park_d;
            ch1_q <= ch1_d;
            ch2_q <= ch2_d;
            tag1_q <= tag1_d;
            tag2_q <= tag2_d;
            clamp_en_q <= clamp_en_d;
            comp_a_q <= comp_a_d;
            comp_b_q <= comp_b_d;
            onehot_q <= onehot_d;
        end
    end

    // reference switch follows the channel and opens for the test
    logic ref_a_q, ref_b_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_a_q <= 1'b1;
            ref_b_q <= 1'b0;
        end else begin
            ref_a_q <= ~comp_d & ~seq_ref_open; // [R11] [R12]
            ref_b_q <= comp_d & ~seq_ref_open; // [R11] [R12]
        end
    end

    // register read mux
    always_comb begin
        rd_data = 32'h0000_0000;
        if (psc_pkg::reg_hit(rd_addr, psc_pkg::OFF_CTRL)) begin
            rd_data[psc_pkg::CTRL_DRV_ON] = drv_bit_q;
            rd_data[psc_pkg::CTRL_CH_SEL] = ch_sel_q;
            rd_data[psc_pkg::CTRL_TAG_ON] = tag_q;
            rd_data[psc_pkg::CTRL_PD_ON] = pd_q;
            rd_data[psc_pkg::CTRL_CLAMP_ON] = clamp_q;
            rd_data[psc_pkg::CTRL_CLAMP_SYM] = sym_q;
            rd_data[psc_pkg::CTRL_COMP_SEL] = comp_q;
            rd_data[psc_pkg::CTRL_GAIN_LSB +: psc_pkg::GAIN_W] = gain_q;
        end else if (psc_pkg::reg_hit(rd_addr, psc_pkg::OFF_TEST)) begin
            rd_data[psc_pkg::TEST_START] = seq_busy;
        end else if (psc_pkg::reg_hit(rd_addr, psc_pkg::OFF_STATUS)) begin
            rd_data[psc_pkg::STAT_DRV_ACTIVE] = drv_act_q;
            rd_data[psc_pkg::STAT_PARKED] = park_q;
            rd_data[psc_pkg::STAT_PULLDOWN] = pd_q;
            rd_data[psc_pkg::STAT_STB_FAULT] = stb_q;
            rd_data[psc_pkg::STAT_TEST_BUSY] = seq_busy;
            rd_data[psc_pkg::STAT_RESULT_VALID] = seq_valid;
        end else if (psc_pkg::reg_hit(rd_addr, psc_pkg::OFF_RESULT)) begin
            rd_data[psc_pkg::RES_OPEN_LSB +: psc_pkg::ADC_W] = res_open; // [R14]
            rd_data[psc_pkg::RES_CLOSED_LSB +: psc_pkg::ADC_W] = res_closed; // [R14]
        end
    end

    // outputs
    assign pump_drv_en = drv_act_q;
    assign park_amp_on = park_q;
    assign ch1_drive_en = ch1_q;
    assign ch2_drive_en = ch2_q;
    assign tag1_sw_on = tag1_q;
    assign tag2_sw_on = tag2_q;
    assign pulldown_sw_on = pd_q;
    assign clamp_en = clamp_en_q;
    assign clamp_symmetric = sym_q; // [R10]
    assign comp_a_en = comp_a_q;
    assign comp_b_en = comp_b_q;
    assign ref_sw_a_on = ref_a_q;
    assign ref_sw_b_on = ref_b_q;
    assign gain_code = gain_q;
    assign gain_onehot = onehot_q;

endmodule : psc_pump_switch_ctrl

/* psc_adc_model.sv */
module psc_adc_model #(
    parameter int DELAY = 7,
    parameter logic [psc_pkg::ADC_W-1:0] OPEN_VAL = 10'h155,
    parameter logic [psc_pkg::ADC_W-1:0] CLOSED_VAL = 10'h2A3
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // converter side
    input wire logic adc_start,
    input wire logic gnd_sw_on,
    output logic adc_done,
    output logic [psc_pkg::ADC_W-1:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    // sense amplifier level follows the ground switch; data toggles when not valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
            adc_done <= 1'b0;
            adc_data <= 10'h000;
        end else begin
            adc_done <= 1'b0;
            adc_data <= ~adc_data;
            if (adc_start) begin
                cnt_q <= DELAY;
            end else if (cnt_q == 1) begin
                cnt_q <= 0;
                adc_done <= 1'b1;
                adc_data <= gnd_sw_on ? CLOSED_VAL : OPEN_VAL;
            end else if (cnt_q > 1) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : psc_adc_model

/* psc_chk.sv */
module psc_chk (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus, fault and converter
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sensor_stb_fault,
    input wire logic adc_start,
    // driver
    input wire logic pump_drv_en,
    input wire logic park_amp_on,
    input wire logic ch1_drive_en,
    input wire logic ch2_drive_en,
    input wire logic tag1_sw_on,
    input wire logic tag2_sw_on,
    input wire logic pulldown_sw_on,
    input wire logic clamp_en,
    // compensation, gain, test
    input wire logic comp_a_en,
    input wire logic comp_b_en,
    input wire logic ref_sw_a_on,
    input wire logic ref_sw_b_on,
    input wire logic [psc_pkg::GAIN_W-1:0] gain_code,
    input wire logic [7:0] gain_onehot,
    input wire logic test_gnd_sw_on,
    input wire logic test_bg_sw_on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    park_off_a: assert property (pump_drv_en [*2] |-> !park_amp_on)
        else $error("parking amp on while driver active");
    park_on_a: assert property (!pump_drv_en [*2] |-> park_amp_on)
        else $error("parking amp off while driver idle");
    fault_gate_a: assert property (sensor_stb_fault [*3] |-> !pump_drv_en)
        else $error("driver active during short to battery");
    pd_drop_a: assert property ((pump_drv_en || sensor_stb_fault) [*3]
        |-> !pulldown_sw_on)
        else $error("pull-down closed while driver active or fault");
    chan_excl_a: assert property (!(ch1_drive_en && ch2_drive_en))
        else $error("both channels driven");
    tag_chan_a: assert property ((tag1_sw_on |-> ch1_drive_en)
        and (tag2_sw_on |-> ch2_drive_en))
        else $error("tag switch closed on undriven channel");
    clamp_drv_a: assert property (clamp_en |-> pump_drv_en || $past(pump_drv_en))
        else $error("clamp on with driver idle");
    comp_excl_a: assert property (comp_a_en != comp_b_en)
        else $error("compensation channel select broken");
    gain_map_a: assert property (gain_onehot == (8'h01 << gain_code))
        else $error("gain one-hot does not match code");
    ref_open_a: assert property ((test_gnd_sw_on || test_bg_sw_on)
        |-> !ref_sw_a_on && !ref_sw_b_on)
        else $error("reference switch closed during test");
    sw_excl_a: assert property (test_bg_sw_on |-> !test_gnd_sw_on)
        else $error("ground and band-gap switches both closed");
    adc_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("converter start longer than one cycle");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus wait or error response");
    drv_c: cover property ($rose(pump_drv_en));
    pd_c: cover property ($rose(pulldown_sw_on));
    bg_c: cover property ($fell(test_bg_sw_on));
endmodule : psc_chk

bind psc_pump_switch_ctrl psc_chk chk_i (.hclk, .hresetn, .hreadyout, .hresp, .sensor_stb_fault,
    .adc_start, .pump_drv_en, .park_amp_on, .ch1_drive_en, .ch2_drive_en, .tag1_sw_on,
    .tag2_sw_on, .pulldown_sw_on, .clamp_en, .comp_a_en, .comp_b_en, .ref_sw_a_on, .ref_sw_b_on,
    .gain_code, .gain_onehot, .test_gnd_sw_on, .test_bg_sw_on);

/* testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, adc_start, adc_done, sensor_stb_fault = 1'b0;
    logic [31:0] hrdata, rd;
    logic [psc_pkg::ADC_W-1:0] adc_data;
    logic pump_drv_en, park_amp_on, ch1_drive_en, ch2_drive_en, tag1_sw_on, tag2_sw_on;
    logic pulldown_sw_on, clamp_en, clamp_symmetric, comp_a_en, comp_b_en, ref_sw_a_on;
    logic ref_sw_b_on, test_gnd_sw_on, test_bg_sw_on;
    logic [psc_pkg::GAIN_W-1:0] gain_code;
    logic [7:0] gain_onehot;
    int err_count = 0;
    int comparisons = 0;

    psc_pump_switch_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sensor_stb_fault, .adc_done, .adc_data,
        .adc_start, .pump_drv_en, .park_amp_on, .ch1_drive_en, .ch2_drive_en, .tag1_sw_on,
        .tag2_sw_on, .pulldown_sw_on, .clamp_en, .clamp_symmetric, .comp_a_en, .comp_b_en,
        .ref_sw_a_on, .ref_sw_b_on, .gain_code, .gain_onehot, .test_gnd_sw_on, .test_bg_sw_on);
    psc_adc_model adc_i (.hclk, .hresetn, .adc_start, .gnd_sw_on(test_gnd_sw_on), .adc_done,
        .adc_data);

    initial begin
        forever #2.5 hclk = ~hclk;
    end

    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    task automatic give_up;
        err_count++;
        report_and_stop();
    endtask : give_up

    task automatic wait_rdy;
        for (int n = 0; n < 100; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        give_up();
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        repeat (2) @(posedge hclk);
    endtask : bus

    task automatic t_reset;
        chk({pump_drv_en, park_amp_on, ch1_drive_en, ch2_drive_en, tag1_sw_on}, 5'b01000);
        chk({pulldown_sw_on, comp_a_en, comp_b_en, gain_onehot}, 11'h601);
        bus(1'b0, psc_pkg::OFF_CTRL, 32'h0);
        chk(rd, psc_pkg::CTRL_RESET);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
    endtask : t_reset

    task automatic t_driver;
        bus(1'b1, psc_pkg::OFF_CTRL, 32'h0);
        chk(pulldown_sw_on, 1'b0);
        bus(1'b1, psc_pkg::OFF_CTRL, 32'h37);
        chk({pump_drv_en, park_amp_on, ch1_drive_en, ch2_drive_en}, 4'b1001);
        chk({tag1_sw_on, tag2_sw_on, clamp_en, clamp_symmetric}, 4'b0111);
        bus(1'b1, psc_pkg::OFF_CTRL, 32'h3F);
        chk(pulldown_sw_on, 1'b0);
        bus(1'b1, psc_pkg::OFF_CTRL, 32'h11);
        chk({ch1_drive_en, ch2_drive_en, tag1_sw_on, clamp_en, clamp_symmetric},
            5'b10010);
        sensor_stb_fault <= 1'b1;
        repeat (4) @(posedge hclk);
        chk({pump_drv_en, park_amp_on, pulldown_sw_on}, 3'b010);
        bus(1'b1, psc_pkg::OFF_CTRL, 32'h08);
        chk(pulldown_sw_on, 1'b0);
        sensor_stb_fault <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b1, psc_pkg::OFF_CTRL, 32'h48);
        chk({pulldown_sw_on, comp_a_en, comp_b_en, ref_sw_b_on}, 4'b1011);
    endtask : t_driver

    task automatic t_gain;
        for (int g = 0; g < 8; g++) begin
            bus(1'b1, psc_pkg::OFF_CTRL, 32'h08 | (g << psc_pkg::CTRL_GAIN_LSB));
            chk({gain_code, gain_onehot}, {g[2:0], 8'h01 << g});
        end
    endtask : t_gain

    task automatic t_imp;
        bus(1'b1, psc_pkg::OFF_TEST, 32'h1);
        chk({ref_sw_a_on, ref_sw_b_on}, 2'b00);
        for (int n = 0; n < 6000 && test_bg_sw_on !== 1'b1; n++) @(posedge hclk);
        if (test_bg_sw_on !== 1'b1) give_up();
        chk({test_bg_sw_on, test_gnd_sw_on}, 2'b10);
        rd = 32'hFFFF_FFFF;
        for (int n = 0; n < 3000 && rd[psc_pkg::STAT_TEST_BUSY] !== 1'b0; n++) begin
            bus(1'b0, psc_pkg::OFF_STATUS, 32'h0);
        end
        if (rd[psc_pkg::STAT_TEST_BUSY] !== 1'b0) give_up();
        chk(rd[psc_pkg::STAT_RESULT_VALID], 1'b1);
        chk({test_bg_sw_on, ref_sw_a_on}, 2'b01);
        bus(1'b0, psc_pkg::OFF_RESULT, 32'h0);
        chk(rd, {6'h0, 10'h2A3, 6'h0, 10'h155});
    endtask : t_imp

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_driver();
        t_gain();
        t_imp();
        report_and_stop();
    end
endmodule : testbench
